// File: core/bcme_pkg.sv
// Shared types and constants for the branch, compare and multiply executor
package bcme_pkg;
    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Execution lengths in core clock cycles
    localparam logic [2:0] LAT_ONE = 3'h1;
    localparam logic [2:0] LAT_TWO = 3'h2;
    localparam logic [2:0] LAT_THREE = 3'h3;
    localparam logic [2:0] LAT_FOUR = 3'h4;

    // Program counter steps
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] SKIP_SHORT = 16'h0002;
    localparam logic [15:0] SKIP_LONG = 16'h0003;

    // Opcode masks
    localparam logic [15:0] MASK_TOP4 = 16'hF000;
    localparam logic [15:0] MASK_TOP6 = 16'hFC00;
    localparam logic [15:0] MASK_SKIPR = 16'hFE08;
    localparam logic [15:0] MASK_BYTE = 16'hFF00;
    localparam logic [15:0] MASK_FRAC = 16'hFF88;
    localparam logic [15:0] MASK_FULL = 16'hFFFF;

    // Opcode match values
    localparam logic [15:0] OPC_TEST = 16'h2000;
    localparam logic [15:0] OPC_MUL = 16'h9C00;
    localparam logic [15:0] OPC_MULT_SIGNED_OP = 16'h0200;
    localparam logic [15:0] OPC_MULT_SIGNED_UNSIGNED_OP = 16'h0300;
    localparam logic [15:0] OPC_FRAC_MULT_UNSIGNED_OP = 16'h0308;
    localparam logic [15:0] OPC_FRAC_MULT_SIGNED_OP = 16'h0380;
    localparam logic [15:0] OPC_FRAC_MULT_MIXED_OP = 16'h0388;
    localparam logic [15:0] OPC_RJUMP = 16'hC000;
    localparam logic [15:0] OPC_RELATIVE_CALL_OP = 16'hD000;
    localparam logic [15:0] OPC_PJUMP = 16'h9409;
    localparam logic [15:0] OPC_PCALL = 16'h9509;
    localparam logic [15:0] OPC_SRET = 16'h9508;
    localparam logic [15:0] OPC_IRET = 16'h9518;
    localparam logic [15:0] OPC_COMPARE_SKIP_EQUAL_OP = 16'h1000;
    localparam logic [15:0] OPC_CP = 16'h1400;
    localparam logic [15:0] OPC_CPC = 16'h0400;
    localparam logic [15:0] OPC_CPI = 16'h3000;
    localparam logic [15:0] OPC_SKRC = 16'hFC00;
    localparam logic [15:0] OPC_SKRS = 16'hFE00;
    localparam logic [15:0] OPC_SKIC = 16'h9900;
    localparam logic [15:0] OPC_SKIS = 16'h9B00;
    localparam logic [15:0] OPC_BFS = 16'hF000;
    localparam logic [15:0] OPC_BFC = 16'hF400;

    typedef enum logic [4:0] {
        unknown_op = 5'h00, test_register_op = 5'h01,
        mult_unsigned_op = 5'h02, mult_signed_op = 5'h03,
        mult_signed_unsigned_op = 5'h04, frac_mult_unsigned_op = 5'h05,
        frac_mult_signed_op = 5'h06, frac_mult_mixed_op = 5'h07,
        relative_jump_op = 5'h08, relative_call_op = 5'h09,
        pointer_jump_op = 5'h0A, pointer_call_op = 5'h0B,
        subroutine_return_op = 5'h0C, interrupt_return_op = 5'h0D,
        compare_skip_equal_op = 5'h0E, compare_regs_op = 5'h0F,
        compare_carry_op = 5'h10, compare_immediate_op = 5'h11,
        skip_reg_bit_clear_op = 5'h12, skip_reg_bit_set_op = 5'h13,
        skip_io_bit_clear_op = 5'h14, skip_io_bit_set_op = 5'h15,
        branch_flag_set_op = 5'h16, branch_flag_clear_op = 5'h17
    } bcme_op_e;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_wait = 1'b1
    } bcme_state_e;

    typedef struct packed {
        logic [15:0] opcode;
        logic [15:0] pc;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] io;
        logic [15:0] zptr;
        logic [15:0] stack;
        logic next_long;
        logic [7:0] status;
    } bcme_req_s;

    typedef struct packed {
        logic [15:0] pc_next;
        logic pair_we;
        logic [15:0] pair_value;
        logic [7:0] flag_we;
        logic [7:0] flag_value;
        logic push;
        logic [15:0] push_addr;
        logic pop;
        logic unknown;
    } bcme_res_s;
endpackage : bcme_pkg

// File: core/bcme_exec.sv
// Executes test, multiply, jump, call, return, compare, skip and branch
`timescale 1ns/1ps

module bcme_exec (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire bcme_pkg::bcme_req_s REQ,
    output logic READY,
    output logic DONE,
    output bcme_pkg::bcme_res_s RESULT
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
                                 input logic [15:0] v);
        return (w & m) == v;
    endfunction : hit

    function automatic bcme_pkg::bcme_op_e decode_op(input logic [15:0] w);
        bcme_pkg::bcme_op_e op;
        op = bcme_pkg::unknown_op;
        // Test is an AND of a register with itself
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_TEST) &&
            ({w[8], w[7:4]} == {w[9], w[3:0]}))
            op = bcme_pkg::test_register_op;
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_MUL))
            op = bcme_pkg::mult_unsigned_op;
        if (hit(w, bcme_pkg::MASK_BYTE, bcme_pkg::OPC_MULT_SIGNED_OP))
            op = bcme_pkg::mult_signed_op;
        if (hit(w, bcme_pkg::MASK_FRAC, bcme_pkg::OPC_MULT_SIGNED_UNSIGNED_OP))
            op = bcme_pkg::mult_signed_unsigned_op;
        if (hit(w, bcme_pkg::MASK_FRAC, bcme_pkg::OPC_FRAC_MULT_UNSIGNED_OP))
            op = bcme_pkg::frac_mult_unsigned_op;
        if (hit(w, bcme_pkg::MASK_FRAC, bcme_pkg::OPC_FRAC_MULT_SIGNED_OP))
            op = bcme_pkg::frac_mult_signed_op;
        if (hit(w, bcme_pkg::MASK_FRAC, bcme_pkg::OPC_FRAC_MULT_MIXED_OP))
            op = bcme_pkg::frac_mult_mixed_op;
        if (hit(w, bcme_pkg::MASK_TOP4, bcme_pkg::OPC_RJUMP))
            op = bcme_pkg::relative_jump_op;
        if (hit(w, bcme_pkg::MASK_TOP4, bcme_pkg::OPC_RELATIVE_CALL_OP))
            op = bcme_pkg::relative_call_op;
        if (hit(w, bcme_pkg::MASK_FULL, bcme_pkg::OPC_PJUMP))
            op = bcme_pkg::pointer_jump_op;
        if (hit(w, bcme_pkg::MASK_FULL, bcme_pkg::OPC_PCALL))
            op = bcme_pkg::pointer_call_op;
        if (hit(w, bcme_pkg::MASK_FULL, bcme_pkg::OPC_SRET))
            op = bcme_pkg::subroutine_return_op;
        if (hit(w, bcme_pkg::MASK_FULL, bcme_pkg::OPC_IRET))
            op = bcme_pkg::interrupt_return_op;
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_COMPARE_SKIP_EQUAL_OP))
            op = bcme_pkg::compare_skip_equal_op;
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_CP))
            op = bcme_pkg::compare_regs_op;
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_CPC))
            op = bcme_pkg::compare_carry_op;
        if (hit(w, bcme_pkg::MASK_TOP4, bcme_pkg::OPC_CPI))
            op = bcme_pkg::compare_immediate_op;
        if (hit(w, bcme_pkg::MASK_SKIPR, bcme_pkg::OPC_SKRC))
            op = bcme_pkg::skip_reg_bit_clear_op;
        if (hit(w, bcme_pkg::MASK_SKIPR, bcme_pkg::OPC_SKRS))
            op = bcme_pkg::skip_reg_bit_set_op;
        if (hit(w, bcme_pkg::MASK_BYTE, bcme_pkg::OPC_SKIC))
            op = bcme_pkg::skip_io_bit_clear_op;
        if (hit(w, bcme_pkg::MASK_BYTE, bcme_pkg::OPC_SKIS))
            op = bcme_pkg::skip_io_bit_set_op;
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_BFS))
            op = bcme_pkg::branch_flag_set_op;
        if (hit(w, bcme_pkg::MASK_TOP6, bcme_pkg::OPC_BFC))
            op = bcme_pkg::branch_flag_clear_op;
        return op;
    endfunction : decode_op

    // Subtract without storing; Z chains for the carry form
    function automatic logic [7:0] sub_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic cin,
                                             input logic zkeep);
        logic [7:0] r;
        logic [7:0] f;
        r = 8'(a - b - {7'h00, cin});
        f = 8'h00;
        f[bcme_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        f[bcme_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        f[bcme_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        f[bcme_pkg::FLAG_N] = r[7];
        f[bcme_pkg::FLAG_Z] = (r == 8'h00) & zkeep;
        f[bcme_pkg::FLAG_S] = f[bcme_pkg::FLAG_N] ^ f[bcme_pkg::FLAG_V];
        return f;
    endfunction : sub_flags

    // Sign or zero extension per operand, low 16 bits of the product
    function automatic logic [15:0] mult(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic sa, input logic sb);
        logic [15:0] ea;
        logic [15:0] eb;
        ea = {{8{sa & a[7]}}, a};
        eb = {{8{sb & b[7]}}, b};
        return 16'(ea * eb);
    endfunction : mult

    function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                               input logic [15:0] k);
        return 16'(pc + k + bcme_pkg::PC_STEP);
    endfunction : rel_target

    ////////////////////////////////////////////////////////////////////////
    bcme_pkg::bcme_state_e state_q;
    bcme_pkg::bcme_op_e op_w;
    bcme_pkg::bcme_res_s nxt_w;
    bcme_pkg::bcme_res_s res_q;
    logic ready_q;
    logic done_q;
    logic [2:0] cnt_q;
    logic [2:0] lat_w;
    logic take_w;
    logic taken_w;
    logic flag_bit_w;
    logic skip_w;
    logic frac_w;
    logic [15:0] prod_w;
    logic [15:0] pair_w;
    logic [7:0] cmp_w;
    logic [2:0] sel_w;

    assign op_w = decode_op(REQ.opcode);
    assign take_w = INSTR_VALID && ready_q;
    assign sel_w = REQ.opcode[2:0];

    // Signed test flag is formed live so stale S never misleads
    always_comb begin
        if (sel_w == 3'(bcme_pkg::FLAG_S))
            flag_bit_w = REQ.status[bcme_pkg::FLAG_N] ^
                         REQ.status[bcme_pkg::FLAG_V];
        else
            flag_bit_w = REQ.status[sel_w];
    end

    always_comb begin
        nxt_w = '0;
        lat_w = bcme_pkg::LAT_ONE;
        taken_w = 1'b0;
        skip_w = 1'b0;
        frac_w = 1'b0;
        prod_w = 16'h0000;
        pair_w = 16'h0000;
        cmp_w = 8'h00;
        nxt_w.pc_next = 16'(REQ.pc + bcme_pkg::PC_STEP);
        unique case (op_w)
            bcme_pkg::test_register_op: begin
                cmp_w = REQ.rd & REQ.rd;
                nxt_w.flag_we[bcme_pkg::FLAG_Z] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_N] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_V] = 1'b1;
                nxt_w.flag_value[bcme_pkg::FLAG_Z] = (cmp_w == 8'h00);
                nxt_w.flag_value[bcme_pkg::FLAG_N] = cmp_w[7];
            end
            bcme_pkg::mult_unsigned_op, bcme_pkg::mult_signed_op,
            bcme_pkg::mult_signed_unsigned_op,
            bcme_pkg::frac_mult_unsigned_op, bcme_pkg::frac_mult_signed_op,
            bcme_pkg::frac_mult_mixed_op: begin
                frac_w = (op_w == bcme_pkg::frac_mult_unsigned_op) ||
                         (op_w == bcme_pkg::frac_mult_signed_op) ||
                         (op_w == bcme_pkg::frac_mult_mixed_op);
                prod_w = mult(REQ.rd, REQ.rr,
                              (op_w != bcme_pkg::mult_unsigned_op) &&
                              (op_w != bcme_pkg::frac_mult_unsigned_op),
                              (op_w == bcme_pkg::mult_signed_op) ||
                              (op_w == bcme_pkg::frac_mult_signed_op));
                // Carry is taken before the fractional shift
                pair_w = frac_w ? {prod_w[14:0], 1'b0}
                                : prod_w;
                nxt_w.pair_we = 1'b1;
                nxt_w.pair_value = pair_w;
                nxt_w.flag_we[bcme_pkg::FLAG_Z] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_C] = 1'b1;
                nxt_w.flag_value[bcme_pkg::FLAG_Z] = (pair_w == 16'h0000);
                nxt_w.flag_value[bcme_pkg::FLAG_C] = prod_w[15];
                lat_w = bcme_pkg::LAT_TWO;
            end
            bcme_pkg::relative_jump_op, bcme_pkg::relative_call_op: begin
                nxt_w.pc_next = rel_target(REQ.pc,
                    {{4{REQ.opcode[11]}}, REQ.opcode[11:0]});
                nxt_w.push = (op_w == bcme_pkg::relative_call_op);
                nxt_w.push_addr = 16'(REQ.pc + bcme_pkg::PC_STEP);
                lat_w = nxt_w.push ? bcme_pkg::LAT_THREE : bcme_pkg::LAT_TWO;
            end
            bcme_pkg::pointer_jump_op: begin
                nxt_w.pc_next = REQ.zptr;
                lat_w = bcme_pkg::LAT_TWO;
            end
            bcme_pkg::pointer_call_op: begin
                nxt_w.pc_next = REQ.zptr;
                nxt_w.push = 1'b1;
                nxt_w.push_addr = 16'(REQ.pc + bcme_pkg::PC_STEP);
                lat_w = bcme_pkg::LAT_THREE;
            end
            bcme_pkg::subroutine_return_op,
            bcme_pkg::interrupt_return_op: begin
                nxt_w.pc_next = REQ.stack;
                nxt_w.pop = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_I] =
                    (op_w == bcme_pkg::interrupt_return_op);
                nxt_w.flag_value[bcme_pkg::FLAG_I] =
                    (op_w == bcme_pkg::interrupt_return_op);
                lat_w = bcme_pkg::LAT_FOUR;
            end
            bcme_pkg::compare_skip_equal_op,
            bcme_pkg::skip_reg_bit_clear_op, bcme_pkg::skip_reg_bit_set_op,
            bcme_pkg::skip_io_bit_clear_op, bcme_pkg::skip_io_bit_set_op: begin
                if (op_w == bcme_pkg::compare_skip_equal_op)
                    skip_w = (REQ.rd == REQ.rr);
                else if (op_w == bcme_pkg::skip_reg_bit_clear_op)
                    skip_w = !REQ.rd[sel_w];
                else if (op_w == bcme_pkg::skip_reg_bit_set_op)
                    skip_w = REQ.rd[sel_w];
                else if (op_w == bcme_pkg::skip_io_bit_clear_op)
                    skip_w = !REQ.io[sel_w];
                else
                    skip_w = REQ.io[sel_w];
                // Skipping a two-word instruction costs one more cycle
                if (skip_w) begin
                    nxt_w.pc_next = 16'(REQ.pc + (REQ.next_long ?
                        bcme_pkg::SKIP_LONG : bcme_pkg::SKIP_SHORT));
                    lat_w = REQ.next_long ? bcme_pkg::LAT_THREE
                                          : bcme_pkg::LAT_TWO;
                end
            end
            bcme_pkg::compare_regs_op, bcme_pkg::compare_carry_op,
            bcme_pkg::compare_immediate_op: begin
                if (op_w == bcme_pkg::compare_immediate_op)
                    cmp_w = sub_flags(REQ.rd,
                        {REQ.opcode[11:8], REQ.opcode[3:0]}, 1'b0, 1'b1);
                else if (op_w == bcme_pkg::compare_carry_op)
                    cmp_w = sub_flags(REQ.rd, REQ.rr,
                        REQ.status[bcme_pkg::FLAG_C],
                        REQ.status[bcme_pkg::FLAG_Z]);
                else
                    cmp_w = sub_flags(REQ.rd, REQ.rr, 1'b0, 1'b1);
                nxt_w.flag_value = cmp_w;
                nxt_w.flag_we[bcme_pkg::FLAG_Z] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_N] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_V] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_C] = 1'b1;
                nxt_w.flag_we[bcme_pkg::FLAG_H] = 1'b1;
            end
            bcme_pkg::branch_flag_set_op, bcme_pkg::branch_flag_clear_op: begin
                taken_w = (op_w == bcme_pkg::branch_flag_set_op) ?
                          flag_bit_w : !flag_bit_w;
                if (taken_w) begin
                    nxt_w.pc_next = rel_target(REQ.pc,
                        {{9{REQ.opcode[9]}}, REQ.opcode[9:3]});
                    lat_w = bcme_pkg::LAT_TWO;
                end
            end
            bcme_pkg::unknown_op: begin
                nxt_w.unknown = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Results latch at acceptance and stand until the next acceptance or a reset
    always_ff @(posedge CLOCK) begin
        if (RST)
            res_q <= '0;
        else if (take_w)
            res_q <= nxt_w;
    end

    // Completion waits out the documented cycle count
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q <= bcme_pkg::st_idle;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            cnt_q <= 3'h0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                bcme_pkg::st_idle: begin
                    if (take_w && (lat_w == bcme_pkg::LAT_ONE)) begin
                        done_q <= 1'b1;
                    end else if (take_w) begin
                        state_q <= bcme_pkg::st_wait;
                        ready_q <= 1'b0;
                        cnt_q <= 3'(lat_w - bcme_pkg::LAT_ONE);
                    end
                end
                bcme_pkg::st_wait: begin
                    cnt_q <= 3'(cnt_q - bcme_pkg::LAT_ONE);
                    if (cnt_q == bcme_pkg::LAT_ONE) begin
                        done_q <= 1'b1;
                        ready_q <= 1'b1;
                        state_q <= bcme_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    assign READY = ready_q;
    assign DONE = done_q;
    assign RESULT = res_q;

    ////////////////////////////////////////////////////////////////////////
    a_test_flags:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::test_register_op |=> DONE &&
        RESULT.flag_we == 8'h0E &&
        RESULT.flag_value[bcme_pkg::FLAG_Z] == ($past(REQ.rd) == 8'h00))
    else $error("test result or timing wrong");

    a_mul_timing:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::mult_unsigned_op |=> !DONE && !READY
        ##1 DONE && RESULT.pair_we && RESULT.flag_we == 8'h03)
    else $error("multiply not done in two cycles");

    a_frac_shift:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::frac_mult_unsigned_op |-> ##2
        RESULT.pair_value == 16'({8'h00, $past(REQ.rd, 2)} *
                                 {8'h00, $past(REQ.rr, 2)} << 1))
    else $error("fractional product not shifted");

    a_frac_signed:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && (op_w == bcme_pkg::frac_mult_signed_op ||
                   op_w == bcme_pkg::frac_mult_mixed_op) |-> ##2
        DONE && RESULT.pair_value[0] == 1'b0 && RESULT.flag_we == 8'h03)
    else $error("signed fractional multiply wrong");

    a_ptr_jump:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::pointer_jump_op |-> ##2 DONE &&
        RESULT.pc_next == $past(REQ.zptr, 2) && RESULT.flag_we == 8'h00)
    else $error("pointer jump target or timing wrong");

    a_ptr_call:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::pointer_call_op |=> !DONE ##1 !DONE
        ##1 DONE && RESULT.push && RESULT.pc_next == $past(REQ.zptr, 3) &&
        RESULT.push_addr == 16'($past(REQ.pc, 3) + 16'h0001))
    else $error("pointer call wrong");

    a_skip_equal:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::compare_skip_equal_op &&
        REQ.rd == REQ.rr && !REQ.next_long |-> ##2 DONE &&
        RESULT.pc_next == 16'($past(REQ.pc, 2) + 16'h0002))
    else $error("equal skip wrong");

    a_branch_idle:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::branch_flag_clear_op &&
        REQ.opcode[2:0] != 3'(bcme_pkg::FLAG_S) &&
        REQ.status[REQ.opcode[2:0]] |=>
        DONE && RESULT.pc_next == 16'($past(REQ.pc) + 16'h0001))
    else $error("untaken branch wrong");

    a_return_ie:
    assert property (@(posedge CLOCK) disable iff (RST)
        take_w && op_w == bcme_pkg::interrupt_return_op |-> ##4 DONE &&
        RESULT.pop && RESULT.flag_value[bcme_pkg::FLAG_I])
    else $error("interrupt return wrong");

endmodule : bcme_exec

// File: verif/bcme_fetch_model.sv
// Fetch-side model that offers one instruction at a time to the executor
`timescale 1ns/1ps
module bcme_fetch_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire bcme_pkg::bcme_req_s req_in,
    input wire logic ready,
    output logic instr_valid,
    output bcme_pkg::bcme_req_s req
);
    // Request held until taken; stale data inverted after release
    always @(posedge clock) begin
        if (rst) begin
            instr_valid <= 1'b0;
            req <= '0;
        end else if (start) begin
            instr_valid <= 1'b1;
            req <= req_in;
        end else if (instr_valid && ready) begin
            instr_valid <= 1'b0;
            req <= ~req;
        end
    end
endmodule : bcme_fetch_model

// File: verif/test_bcme.sv
// Self-checking bench for the branch, compare and multiply executor
`timescale 1ns/1ps
module test_branch_compare_multiply_exec;
    logic clock, rst, start, instr_valid, ready, done;
    bcme_pkg::bcme_req_s req, dut_req;
    bcme_pkg::bcme_res_s result;
    int err_total = 0;
    int checks = 0;
    bcme_fetch_model fetch (.clock(clock), .rst(rst), .start(start),
        .req_in(req), .ready(ready), .instr_valid(instr_valid),
        .req(dut_req));
    bcme_exec DUT (.CLOCK(clock), .RST(rst), .INSTR_VALID(instr_valid),
        .REQ(dut_req), .READY(ready), .DONE(done), .RESULT(result));
    initial clock = 1'b0;
    always #10 clock = ~clock;
////////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic bcme_pkg::bcme_req_s mk(logic [15:0] op,
            logic [7:0] a, logic [7:0] b, logic [7:0] st, logic nl);
        mk = '0;
        mk.opcode = op;
        mk.pc = 16'h0100;
        mk.rd = a;
        mk.rr = b;
        mk.io = a;
        mk.status = st;
        mk.zptr = 16'h1234;
        mk.stack = 16'h0ABC;
        mk.next_long = nl;
    endfunction : mk
    // Counts edges from the take edge to the one that shows done
    task automatic run(input bcme_pkg::bcme_req_s r, input int lat,
            input logic [15:0] pc, input logic [7:0] we);
        int n = 0;
        @(posedge clock);
        start <= 1'b1;
        req <= r;
        @(posedge clock);
        start <= 1'b0;
        #1;
        while (ready !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (done !== 1'b1 && n < 8);
        chk(n, lat);
        chk(result.pc_next, pc);
        chk(result.flag_we, we);
    endtask : run
    task automatic rz(input logic [15:0] op, input logic [7:0] st,
            input int lat, input logic [15:0] pc, input logic [7:0] we);
        run(mk(op, 8'h00, 8'h00, st, 1'b0), lat, pc, we);
    endtask : rz
    // Reset in mid-flight drops the pending return at once
    task automatic t_reset;
        @(posedge clock);
        start <= 1'b1;
        req <= mk(16'h9518, 8'h00, 8'h00, 8'h00, 1'b0);
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        #1;
        chk({ready, done}, 2'h0);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        chk({ready, done, result.pc_next}, 18'h20000);
        @(posedge clock);
        #1;
        chk({ready, done, result.pop}, 3'h4);
    endtask : t_reset
////////////////////////////////////////////////////////////////////////////
    task automatic t_mult;
        logic [15:0] op [7] = '{16'h9C00, 16'h0200, 16'h0300, 16'h0308,
            16'h0380, 16'h0388, 16'h9C00};
        logic [7:0] a [7] = '{8'hFF, 8'h80, 8'hFF, 8'h80, 8'h80, 8'hFF, 8'h00};
        logic [7:0] b [7] = '{8'hFF, 8'hFF, 8'h02, 8'h80, 8'h80, 8'h02, 8'h37};
        logic [15:0] p [7] = '{16'hFE01, 16'h0080, 16'hFFFE, 16'h8000,
            16'h8000, 16'hFFFC, 16'h0000};
        logic [1:0] zc [7] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2};
        for (int i = 0; i < 7; i++) begin
            run(mk(op[i], a[i], b[i], 8'h00, 1'b0), 2, 16'h0101,
                8'h03);
            chk({result.pair_we, result.pair_value},
                {1'b1, p[i]});
            chk(result.flag_value[1:0], zc[i]);
        end
    endtask : t_mult
    task automatic t_cmp;
        logic [15:0] op [5] = '{16'h1400, 16'h3001, 16'h0400, 16'h0400,
            16'h1400};
        logic [7:0] a [5] = '{8'h10, 8'h10, 8'h05, 8'h05, 8'h80};
        logic [7:0] b [5] = '{8'h20, 8'h00, 8'h04, 8'h04, 8'h01};
        logic [7:0] st [5] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
        logic [7:0] e [5] = '{8'h05, 8'h20, 8'h00, 8'h02, 8'h28};
        for (int i = 0; i < 5; i++) begin
            run(mk(op[i], a[i], b[i], st[i], 1'b0), 1, 16'h0101,
                8'h2F);
            chk(result.flag_value & 8'h2F, e[i]);
        end
        run(mk(16'h2000, 8'h80, 8'h80, 8'h00, 1'b0), 1, 16'h0101,
            8'h0E);
        chk(result.flag_value[3:1], 3'h2);
    endtask : t_cmp
    task automatic t_skip;
        logic [15:0] op [7] = '{16'h1000, 16'h1000, 16'h1000, 16'hFC03,
            16'hFE03, 16'h9903, 16'h9B03};
        logic [7:0] a [7] = '{8'h07, 8'h07, 8'h07, 8'hF7, 8'hF7, 8'h08, 8'h08};
        logic [7:0] b [7] = '{8'h07, 8'h07, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
        int lat [7] = '{2, 3, 1, 2, 1, 1, 3};
        for (int i = 0; i < 7; i++) begin
            run(mk(op[i], a[i], b[i], 8'h00, lat[i] == 3), lat[i],
                16'h0100 + 16'(lat[i]), 8'h00);
        end
    endtask : t_skip
    task automatic t_flow;
        rz(16'h9409, 8'h00, 2, 16'h1234, 8'h00);
        rz(16'h9509, 8'h00, 3, 16'h1234, 8'h00);
        chk(result.push_addr, 16'h0101);
        rz(16'hCFFF, 8'h00, 2, 16'h0100, 8'h00);
        rz(16'hD010, 8'h00, 3, 16'h0111, 8'h00);
        chk({result.push, result.push_addr}, 17'h10101);
        rz(16'h9508, 8'h00, 4, 16'h0ABC, 8'h00);
        chk(result.pop, 1'b1);
        rz(16'h9518, 8'h00, 4, 16'h0ABC, 8'h80);
        chk(result.flag_value[7], 1'b1);
        // No match: one cycle, marked, nothing written
        rz(16'h0000, 8'h00, 1, 16'h0101, 8'h00);
        chk({result.unknown, result.pair_we, result.push, result.pop}, 4'h8);
    endtask : t_flow
    // Offset of -64 checks the backward target arithmetic
    task automatic t_branch;
        logic [7:0] st;
        logic tk;
        for (int s = 0; s < 8; s++) begin
            for (int f = 0; f < 4; f++) begin
                st = f[0] ? ((s == 4) ? 8'h04 : 8'(1 << s)) : 8'h00;
                tk = f[0] == f[1];
                run(mk((f[1] ? 16'hF200 : 16'hF600) | 16'(s), 8'h00, 8'h00,
                    st, 1'b0), tk ? 2 : 1, tk ? 16'h00C1 : 16'h0101,
                    8'h00);
            end
        end
        rz(16'hF604, 8'h0C, 2, 16'h00C1, 8'h00);
        rz(16'hF204, 8'h08, 2, 16'h00C1, 8'h00);
    endtask : t_branch
////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        start = 1'b0;
        req = '0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_mult();
        t_cmp();
        t_skip();
        t_flow();
        t_reset();
        t_branch();
        complete_run();
    end
    initial begin
        #100us;
        err_total++;
        complete_run();
    end
endmodule : test_branch_compare_multiply_exec
